/* File: include/rsl_defs.vh */
// constants for the reset strap latch and boot select block
`ifndef RSL_DEFS_VH
`define RSL_DEFS_VH

// -----------------------------------------------------------------
// strap positions on the shared low expansion address pins
// -----------------------------------------------------------------
`define RSL_NUM_STRAPS       13
`define RSL_BIT_PCIE_ROOT    0
`define RSL_BIT_MAC0_LSB     1
`define RSL_BIT_MAC0_MSB     2
`define RSL_BIT_MAC1_LSB     3
`define RSL_BIT_MAC1_MSB     4
`define RSL_BIT_BOOT_LSB     5
`define RSL_BIT_BOOT_MSB     6
`define RSL_BIT_TDM_CLKOUT   7
`define RSL_BIT_SWOPT0       8
`define RSL_BIT_SWOPT1       9
`define RSL_BIT_NAND         10
`define RSL_BIT_PCIE_REFCLK  11
`define RSL_BIT_SPARE        12

// -----------------------------------------------------------------
// reset value of the latched straps
// -----------------------------------------------------------------
`define RSL_STRAP_RESET      13'h0000

// -----------------------------------------------------------------
// capture timing after reset release
// -----------------------------------------------------------------
// three sync stages plus the agreement filter need four edges, so the
// capture waits for the fifth edge to see the settled pin level
`define RSL_SETTLE_LAST      3'h4

// -----------------------------------------------------------------
// boot source codes
// -----------------------------------------------------------------
`define RSL_BOOT_SPI         2'h0
`define RSL_BOOT_I2C         2'h1
`define RSL_BOOT_NOR8        2'h2
`define RSL_BOOT_NOR16       2'h3

// -----------------------------------------------------------------
// boot sequencer states, one-hot
// -----------------------------------------------------------------
`define RSL_ST_W             6
`define RSL_ST_IDLE          6'h01
`define RSL_ST_ROM           6'h02
`define RSL_ST_COPY          6'h04
`define RSL_ST_RAM           6'h08
`define RSL_ST_DDR           6'h10
`define RSL_ST_XIP           6'h20

`endif

/* File: logic/rsl_sync3.v */
// three-flop synchroniser with second/third agreement filter
`include "rsl_defs.vh"

module rsl_sync3
(
  // clock and reset
  input  wire         clock,
  input  wire         rst_n,
  input  wire         clkEn,
  // data
  input  wire         din,
  output reg          dout
);

  reg  s1_r;
  reg  s2_r;
  reg  s3_r;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end
    else if (clkEn)
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // a change counts only once two settled stages agree
      if (s2_r == s3_r)
        dout <= s3_r;
    end
  end

endmodule // rsl_sync3

/* File: logic/rsl_strap_latch.v */
// reset strap latch with boot source decode and boot sequencing
`include "rsl_defs.vh"

module rsl_strap_latch
(
  // clock, reset, enable
  input  wire                          clock,
  input  wire                          rst_n,
  input  wire                          clkEn,
  // shared address / strap pins
  input  wire [`RSL_NUM_STRAPS-1:0]    addrPinIn,
  output reg  [`RSL_NUM_STRAPS-1:0]    addrPinOut,
  output reg  [`RSL_NUM_STRAPS-1:0]    addrPinOe,
  // expansion bus address from the bus controller
  input  wire [`RSL_NUM_STRAPS-1:0]    expAddr,
  input  wire                          expAddrEn,
  // decoded operating modes
  output reg                           pcieRootMode,
  output reg  [1:0]                    mac0Type,
  output reg  [1:0]                    mac1Type,
  output reg                           tdmClkOutEn,
  output reg  [1:0]                    swBootOption,
  output reg                           expNandMode,
  output reg                           pcieRefclkSel,
  output reg  [1:0]                    bootSource,
  output reg                           bootInternal,
  output reg                           norWide,
  output reg                           serialI2c,
  output reg                           strapValid,
  // tdm bit clock pin
  input  wire                          tdmBitClockInt,
  output reg                           tdmBitClockOut,
  output reg                           tdmBitClockOe,
  // boot progress handshakes
  input  wire                          romCopyDone,
  input  wire                          ramCopyDone,
  output reg                           fetchFromNor,
  output reg                           fetchFromRom,
  output reg                           fetchFromRam,
  output reg                           fetchFromDdr,
  output reg                           romCopyReq,
  output reg                           ramCopyReq
);

  // -----------------------------------------------------------------
  // strap sampling
  // -----------------------------------------------------------------
  wire [`RSL_NUM_STRAPS-1:0] strapSync;
  reg  [`RSL_NUM_STRAPS-1:0] strap_r;
  reg                        latched_r;
  reg  [2:0]                 settle_r;

  genvar gi;
  generate
    for (gi = 0; gi < `RSL_NUM_STRAPS; gi = gi + 1)
    begin : g_sync
      rsl_sync3 u_sync
      (
        .clock (clock),
        .rst_n (rst_n),
        .clkEn (clkEn),
        .din   (addrPinIn[gi]),
        .dout  (strapSync[gi])
      );
    end
  endgenerate

  // the pins are held by resistors across release, so the synchronised
  // value a few cycles after release equals the level at the edge;
  // settle_r waits out the synchroniser before capturing
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_r   <= `RSL_STRAP_RESET;
      latched_r <= 1'b0;
      settle_r  <= 3'h0;
    end
    else if (clkEn)
    begin
      if (!latched_r)
      begin
        if (settle_r == `RSL_SETTLE_LAST)
        begin
          strap_r   <= strapSync;
          latched_r <= 1'b1;
        end
        else
          settle_r <= settle_r + 3'h1;
      end
      // once latched nothing reloads strap_r until reset
    end
  end

  // -----------------------------------------------------------------
  // pin drivers
  // -----------------------------------------------------------------
  // drivers stay off until the capture is done so the bus cannot
  // overwrite a strap that is still being sampled
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addrPinOut <= 13'h0000;
      addrPinOe  <= 13'h0000;
    end
    else if (clkEn)
    begin
      addrPinOut <= expAddr;
      addrPinOe  <= (latched_r && expAddrEn) ? 13'h1fff : 13'h0000;
    end
  end

  // -----------------------------------------------------------------
  // mode decode
  // -----------------------------------------------------------------
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pcieRootMode  <= 1'b0;
      mac0Type      <= 2'h0;
      mac1Type      <= 2'h0;
      tdmClkOutEn   <= 1'b0;
      swBootOption  <= 2'h0;
      expNandMode   <= 1'b0;
      pcieRefclkSel <= 1'b0;
      bootSource    <= `RSL_BOOT_SPI;
      bootInternal  <= 1'b0;
      norWide       <= 1'b0;
      serialI2c     <= 1'b0;
      strapValid    <= 1'b0;
    end
    else if (clkEn)
    begin
      strapValid    <= latched_r;
      pcieRootMode  <= strap_r[`RSL_BIT_PCIE_ROOT];
      mac0Type      <= {strap_r[`RSL_BIT_MAC0_MSB], strap_r[`RSL_BIT_MAC0_LSB]};
      mac1Type      <= {strap_r[`RSL_BIT_MAC1_MSB], strap_r[`RSL_BIT_MAC1_LSB]};
      tdmClkOutEn   <= strap_r[`RSL_BIT_TDM_CLKOUT];
      swBootOption  <= {strap_r[`RSL_BIT_SWOPT1], strap_r[`RSL_BIT_SWOPT0]};
      expNandMode   <= strap_r[`RSL_BIT_NAND];
      // refclk strap is passed on as sampled; board keeps it correct
      pcieRefclkSel <= strap_r[`RSL_BIT_PCIE_REFCLK];
      bootSource    <= {strap_r[`RSL_BIT_BOOT_MSB], strap_r[`RSL_BIT_BOOT_LSB]};
      bootInternal  <= !strap_r[`RSL_BIT_BOOT_MSB];
      norWide       <= strap_r[`RSL_BIT_BOOT_MSB] & strap_r[`RSL_BIT_BOOT_LSB];
      serialI2c     <= !strap_r[`RSL_BIT_BOOT_MSB] & strap_r[`RSL_BIT_BOOT_LSB];
    end
  end

  // -----------------------------------------------------------------
  // tdm bit clock output
  // -----------------------------------------------------------------
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tdmBitClockOut <= 1'b0;
      tdmBitClockOe  <= 1'b0;
    end
    else if (clkEn)
    begin
      tdmBitClockOut <= tdmBitClockInt;
      tdmBitClockOe  <= strapValid & tdmClkOutEn;
    end
  end

  // -----------------------------------------------------------------
  // boot sequencer
  // -----------------------------------------------------------------
  localparam [`RSL_ST_W-1:0] ST_IDLE = `RSL_ST_IDLE;
  localparam [`RSL_ST_W-1:0] ST_ROM  = `RSL_ST_ROM;
  localparam [`RSL_ST_W-1:0] ST_COPY = `RSL_ST_COPY;
  localparam [`RSL_ST_W-1:0] ST_RAM  = `RSL_ST_RAM;
  localparam [`RSL_ST_W-1:0] ST_DDR  = `RSL_ST_DDR;
  localparam [`RSL_ST_W-1:0] ST_XIP  = `RSL_ST_XIP;

  reg [`RSL_ST_W-1:0] state_r;
  reg [`RSL_ST_W-1:0] state_nxt;

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (strapValid)
        begin
          if (bootInternal)
            state_nxt = ST_ROM;
          else
            state_nxt = ST_XIP;
        end
      ST_ROM:
        state_nxt = ST_COPY;
      ST_COPY:
        if (romCopyDone)
          state_nxt = ST_RAM;
      ST_RAM:
        if (ramCopyDone)
          state_nxt = ST_DDR;
      ST_DDR:
        state_nxt = ST_DDR;
      ST_XIP:
        state_nxt = ST_XIP;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= ST_IDLE;
    else if (clkEn)
      state_r <= state_nxt;
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fetchFromNor <= 1'b0;
      fetchFromRom <= 1'b0;
      fetchFromRam <= 1'b0;
      fetchFromDdr <= 1'b0;
      romCopyReq   <= 1'b0;
      ramCopyReq   <= 1'b0;
    end
    else if (clkEn)
    begin
      fetchFromNor <= (state_nxt == ST_XIP);
      fetchFromRom <= (state_nxt == ST_ROM) || (state_nxt == ST_COPY);
      fetchFromRam <= (state_nxt == ST_RAM);
      fetchFromDdr <= (state_nxt == ST_DDR);
      romCopyReq   <= (state_nxt == ST_COPY);
      ramCopyReq   <= (state_nxt == ST_RAM);
    end
  end

endmodule // rsl_strap_latch

/* File: testbench/rsl_board_model.sv */
// board strap resistors and serial boot memory stand-in
module rsl_board_model
(
  // clock
  input  logic        clock,
  // strap pins
  input  logic [12:0] strapLevel,
  input  logic [12:0] pinOut,
  input  logic [12:0] pinOe,
  output logic [12:0] pinIn,
  // copy handshakes
  input  int          lag,
  input  logic        romReq,
  input  logic        ramReq,
  output logic        romDone,
  output logic        ramDone
);
  timeunit 1ns;
  timeprecision 1ps;
  int romCnt = 0;
  int ramCnt = 0;
  // an undriven pin settles at its resistor level
  assign pinIn = (pinOe & pinOut) | (~pinOe & strapLevel);
  assign romDone = romReq && (romCnt >= lag);
  assign ramDone = ramReq && (ramCnt >= lag);
  always @(posedge clock)
  begin
    romCnt <= romReq ? romCnt + 1 : 0;
    ramCnt <= ramReq ? ramCnt + 1 : 0;
  end
endmodule // rsl_board_model

/* File: testbench/rsl_strap_latch_chk.sv */
// concurrent checks on the strap latch ports
module rsl_strap_latch_chk
(
  // clock and reset
  input wire        clock,
  input wire        rst_n,
  // pins and bus
  input wire [12:0] addrPinOe,
  input wire        expAddrEn,
  // modes
  input wire        pcieRootMode,
  input wire [1:0]  mac0Type,
  input wire [1:0]  mac1Type,
  input wire        tdmClkOutEn,
  input wire [1:0]  bootSource,
  input wire        bootInternal,
  input wire        norWide,
  input wire        serialI2c,
  input wire        strapValid,
  input wire        tdmBitClockOe,
  // boot progress
  input wire        romCopyDone,
  input wire        ramCopyDone,
  input wire        fetchFromNor,
  input wire        fetchFromRom,
  input wire        fetchFromDdr,
  input wire        romCopyReq,
  input wire        ramCopyReq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_oe_needs_en: assert property ($past(!expAddrEn) |-> addrPinOe == 13'h0000)
    else $error("pin drivers on without bus enable");
  a_valid_holds: assert property (strapValid |=> strapValid)
    else $error("strap valid dropped");
  a_modes_frozen: assert property (strapValid && $past(strapValid)
    |-> $stable({pcieRootMode, mac0Type, mac1Type, bootSource}))
    else $error("latched modes changed");
  a_tdm_drive: assert property (tdmBitClockOe == $past(strapValid && tdmClkOutEn))
    else $error("tdm clock enable wrong");
  a_boot_inner: assert property (strapValid |-> bootInternal == !bootSource[1])
    else $error("internal boot decode wrong");
  a_i2c_pick: assert property (strapValid |-> serialI2c == (bootSource == 2'h1))
    else $error("i2c decode wrong");
  a_nor_wide: assert property (strapValid |-> norWide == (bootSource == 2'h3))
    else $error("nor width decode wrong");
  a_xip_nocopy: assert property (fetchFromNor |-> !romCopyReq && !fetchFromRom)
    else $error("copy during nor boot");
  a_rom_to_ram: assert property ($rose(ramCopyReq) |-> $past(romCopyReq && romCopyDone))
    else $error("ram stage without rom copy");
  a_ram_to_ddr: assert property ($rose(fetchFromDdr) |-> $past(ramCopyReq && ramCopyDone))
    else $error("ddr jump without ram copy");
endmodule // rsl_strap_latch_chk

bind rsl_strap_latch rsl_strap_latch_chk i_rsl_strap_latch_chk (.*);

/* File: testbench/tb_top.sv */
// self-checking bench for the reset strap latch
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [12:0] s; logic [2:0] e;} rsl_row_t;
  // -------------------------------------------------------------
  // straps beside expected {internal, nor16, i2c}
  // refclk strap high only where pcie root is set
  // -------------------------------------------------------------
  rsl_row_t rows [4] = '{'{13'h0803, 3'h4}, '{13'h01b8, 3'h5},
                         '{13'h0644, 3'h0}, '{13'h10ee, 3'h2}};
  logic clock = 0, rst_n = 0, expAddrEn = 0, tdmInt = 0;
  logic [12:0] strap = 13'h0000, expAddr = 13'h0000, pinIn, pinOut, pinOe;
  logic pcie, nandM, refclk, tdmEn, tdmOut, tdmOe, bInt, nWide, i2c, valid;
  logic fNor, fRom, fRam, fDdr, romReq, ramReq, romDone, ramDone;
  logic [1:0] m0, m1, sw, boot;
  int err_count = 0, total_checks = 0, lag = 0, w;
  always #12.5 clock = ~clock;
  rsl_board_model i_rsl_board_model (.clock(clock), .strapLevel(strap), .pinOut(pinOut),
    .pinOe(pinOe), .pinIn(pinIn), .lag(lag), .romReq(romReq), .ramReq(ramReq),
    .romDone(romDone), .ramDone(ramDone));
  rsl_strap_latch i_rsl_strap_latch (.clock(clock), .rst_n(rst_n), .clkEn(1'b1),
    .addrPinIn(pinIn), .addrPinOut(pinOut), .addrPinOe(pinOe), .expAddr(expAddr),
    .expAddrEn(expAddrEn), .pcieRootMode(pcie), .mac0Type(m0), .mac1Type(m1),
    .tdmClkOutEn(tdmEn), .swBootOption(sw), .expNandMode(nandM), .pcieRefclkSel(refclk),
    .bootSource(boot), .bootInternal(bInt), .norWide(nWide), .serialI2c(i2c),
    .strapValid(valid), .tdmBitClockInt(tdmInt), .tdmBitClockOut(tdmOut),
    .tdmBitClockOe(tdmOe), .romCopyDone(romDone), .ramCopyDone(ramDone),
    .fetchFromNor(fNor), .fetchFromRom(fRom), .fetchFromRam(fRam),
    .fetchFromDdr(fDdr), .romCopyReq(romReq), .ramCopyReq(ramReq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // straps stay resistor-held across the release, as the board keeps them
  task automatic boot_up(input logic [12:0] s);
    rst_n = 0;
    expAddrEn = 0;
    strap = s;
    cyc(12);
    rst_n = 1;
    w = 0;
    while (valid !== 1'b1 && w < 20)
    begin
      cyc(1);
      w++;
    end
  endtask
  function automatic logic [12:0] modes();
    return {1'b0, refclk, nandM, sw, tdmEn, boot, m1, m0, pcie};
  endfunction
  initial
  begin
    #50000;
    err_count++;
    wrap_up();
  end
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      lag = i * 3;
      tdmInt = i[0];
      boot_up(rows[i].s);
      chk(modes(), {1'b0, rows[i].s[11:0]});
      chk({bInt, nWide, i2c}, rows[i].e);
      cyc(1);
      chk(tdmOe, rows[i].s[7]);
      chk(tdmOut, i[0]);
      w = 0;
      while (fNor !== 1'b1 && fDdr !== 1'b1 && w < 60)
      begin
        cyc(1);
        w++;
      end
      chk({fNor, fDdr, fRam}, {~rows[i].e[2], rows[i].e[2], 1'b0});
      $display("row %0d done", i);
    end
    strap = ~strap;
    expAddr = 13'h1abc;
    expAddrEn = 1;
    cyc(4);
    chk(modes(), {1'b0, rows[3].s[11:0]});
    chk(pinOe, 13'h1fff);
    chk(pinOut, 13'h1abc);
    $display("pin reuse test done");
    lag = 50;
    boot_up(rows[0].s);
    cyc(3);
    chk({romReq, fRom, fRam}, 3'h6);
    rst_n = 0;
    expAddrEn = 1;
    cyc(1);
    chk(pinOe, 13'h0000);
    chk({valid, fRom, romReq, modes()}, 13'h0000);
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule // tb_top
